// [bootseq_consts.svh]
`ifndef BOOTSEQ_CONSTS_SVH
`define BOOTSEQ_CONSTS_SVH

// bit period limits in platform clock cycles
`define BSEQ_DIV_MIN     16'h00a0
`define BSEQ_DIV_MAX     16'h8000
// cycles the line filter lags a released bus clock
`define BSEQ_SYNC_LAT    14'h0004
// strap code that selects sequencer mode
`define BSEQ_STRAP_SEL   2'h2
// serial rom device codes and start location
`define BSEQ_DEV_WR      8'ha0
`define BSEQ_DEV_RD      8'ha1
`define BSEQ_ROM_START   16'h0000
// record byte 0 flag positions
`define BSEQ_ALT_BIT     7
`define BSEQ_END_BIT     6
// last byte index of a seven byte record
`define BSEQ_REC_LAST    3'h6
// default register space base and target
`define BSEQ_DEF_BASE    12'h0000
`define BSEQ_DEF_TARGET  4'h0
// fifo shape
`define BSEQ_FIFO_W      53
`define BSEQ_FIFO_D      32

`endif

// [bootseq_pkg.sv]
package bootseq_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        S_WAIT, S_START, S_TX, S_RSTART, S_RX, S_PUSH, S_STOP, S_FINISH
    } seq_state_t;

    // one decoded record as it travels through the fifo
    typedef struct packed {
        logic        alt;
        logic [19:0] offset;
        logic [31:0] data;
    } rec_t;

endpackage

// [i2c_boot_sequencer.sv]
`timescale 1ns/100ps
`include "bootseq_consts.svh"

// What this block does
// [R1] load rom values into registers before boot
// [R2] bit period programmable from 160 to 32768
// [R3] mode chosen from straps once, when lock is first seen after reset
// [R4] select bit steers write to alternate space
// [R5] address is alternate base joined to offset
// [R6] alternate writes go to selected target unit
// [R7] each base value opens one megabyte window
// [R8] wait for reset release and lock first
// [R9] master reads rom records sequentially over serial bus
module i2c_boot_sequencer (
    input  wire logic        clk,                    // platform clock
    input  wire logic        sys_rst,                // synchronous reset
    input  wire logic [1:0]  boot_mode_strap_inputs, // mode straps, async
    input  wire logic        dll_locked,             // delay loops locked, async
    input  wire logic [15:0] clk_div,                // bit period in cycles
    input  wire logic [11:0] alt_space_base_reg,     // alternate base, addr 31:20
    input  wire logic [3:0]  alt_space_target_reg,   // alternate target unit
    input  wire logic        scl_i,                  // clock line level
    output logic             scl_o,                  // clock line drive value
    output logic             scl_oe_n,               // low while pulling clock
    input  wire logic        sda_i,                  // data line level
    output logic             sda_o,                  // data line drive value
    output logic             sda_oe_n,               // low while pulling data
    output logic             wr_valid,               // register write pending
    input  wire logic        wr_ready,               // write taken
    output logic [31:0]      wr_addr,                // full target address
    output logic [31:0]      wr_data,                // value to write
    output logic             wr_alt,                 // write through alternate space
    output logic [3:0]       wr_target,              // target unit
    output logic             boot_active,            // loading in progress
    output logic             boot_done,              // loading finished, drained
    output logic             boot_error              // rom refused a byte
);
    bootseq_pkg::seq_state_t st_ff, nxt_st;
    logic [4:0]  syn1_ff, syn2_ff, syn3_ff, flt_ff, nxt_flt;
    logic [1:0]  q_ff, nxt_q;
    logic [13:0] tk_ff, nxt_tk, qtr;
    logic [15:0] dv;
    logic [3:0]  bit_ff, nxt_bit;
    logic [7:0]  sh_ff, nxt_sh;
    logic [2:0]  txn_ff, nxt_txn, rxn_ff, nxt_rxn;
    logic [55:0] rec_ff, nxt_rec;
    logic        scl_low_ff, nxt_scl_low, sda_low_ff, nxt_sda_low;
    logic        boot_en_ff, nxt_boot_en, taken_ff, nxt_taken;
    logic        done_ff, nxt_done, err_ff, nxt_err, nack_ff, nxt_nack;
    logic        tick, hold, out_load;
    logic        wv_ff, nxt_wv, walt_ff, nxt_walt;
    logic [31:0] wa_ff, nxt_wa, wd_ff, nxt_wd;
    logic [3:0]  wt_ff, nxt_wt;
    bootseq_pkg::rec_t rin, rout;
    logic [1:0]  strap_flt;
    logic        lock_flt, sda_flt, scl_flt;

    rec_fifo_if #(.W(`BSEQ_FIFO_W)) fq ();

    rec_fifo #(.W(`BSEQ_FIFO_W), .D(`BSEQ_FIFO_D)) u_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .f       (fq.buf_side)
    );

    // three stage input filter, change taken when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_flt
            assign nxt_flt[gi] = (syn2_ff[gi] == syn3_ff[gi]) ? syn3_ff[gi] : flt_ff[gi];
        end
    endgenerate
    assign strap_flt = flt_ff[1:0];
    assign lock_flt  = flt_ff[2];
    assign sda_flt   = flt_ff[3];
    assign scl_flt   = flt_ff[4];

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            syn1_ff <= '0;
            syn2_ff <= '0;
            syn3_ff <= '0;
            flt_ff  <= '0;
        end
        else
        begin
            syn1_ff <= {scl_i, sda_i, dll_locked, boot_mode_strap_inputs};
            syn2_ff <= syn1_ff;
            syn3_ff <= syn2_ff;
            flt_ff  <= nxt_flt;
        end
    end

    // [R2] clamp divider
    assign dv   = (clk_div < `BSEQ_DIV_MIN) ? `BSEQ_DIV_MIN :
                  (clk_div > `BSEQ_DIV_MAX) ? `BSEQ_DIV_MAX : clk_div;
    assign qtr  = dv[15:2];
    // stretch: released clock still low once the filter lag has passed
    // counting through the lag keeps an unstretched bit at the full period
    assign hold = !scl_low_ff && !scl_flt && (tk_ff >= `BSEQ_SYNC_LAT);
    assign tick = (tk_ff == qtr - 14'h0001) && !hold;

    // rom read sequence bytes
    function automatic logic [7:0] txb(input logic [2:0] idx);
        case (idx)
            3'h0:    txb = `BSEQ_DEV_WR;
            3'h1:    txb = 8'(`BSEQ_ROM_START >> 8);
            3'h2:    txb = 8'(`BSEQ_ROM_START);
            default: txb = `BSEQ_DEV_RD;
        endcase
    endfunction

    assign rin.alt    = rec_ff[48+`BSEQ_ALT_BIT];
    assign rin.offset = {rec_ff[51:48], rec_ff[47:32]};
    assign rin.data   = rec_ff[31:0];
    assign fq.push_valid = (st_ff == bootseq_pkg::S_PUSH);
    assign fq.push_data  = rin;

    // sequencer next state
    always_comb
    begin
        nxt_st = st_ff;  nxt_q = q_ff;  nxt_bit = bit_ff;  nxt_sh = sh_ff;
        nxt_txn = txn_ff;  nxt_rxn = rxn_ff;  nxt_rec = rec_ff;
        nxt_scl_low = scl_low_ff;  nxt_sda_low = sda_low_ff;
        nxt_boot_en = boot_en_ff;  nxt_taken = taken_ff;
        nxt_err = err_ff;  nxt_nack = nack_ff;
        nxt_tk = (tick || st_ff == bootseq_pkg::S_WAIT) ? 14'h0000 :
                 (hold ? tk_ff : tk_ff + 14'h0001);
        nxt_done = (st_ff == bootseq_pkg::S_FINISH) && !fq.pop_valid && !wv_ff;
        if (tick)
            nxt_q = q_ff + 2'h1;
        case (st_ff)
            bootseq_pkg::S_WAIT:
            begin
                // [R8] start only once lock is seen
                // [R3] strap sampled once at lock
                if (lock_flt && !taken_ff)
                begin
                    nxt_taken   = 1'b1;
                    nxt_boot_en = (strap_flt == `BSEQ_STRAP_SEL);
                    nxt_q       = 2'h0;
                    nxt_st      = (strap_flt == `BSEQ_STRAP_SEL) ? bootseq_pkg::S_START
                                                                : bootseq_pkg::S_FINISH;
                end
            end
            bootseq_pkg::S_START, bootseq_pkg::S_RSTART:
            begin
                // [R9] start and repeated start conditions
                if (tick)
                    case (q_ff)
                        2'h0: nxt_sda_low = (st_ff == bootseq_pkg::S_START);
                        2'h1: nxt_scl_low = 1'b0;
                        2'h2:
                        begin
                            nxt_sda_low = 1'b1;
                            nxt_scl_low = (st_ff == bootseq_pkg::S_START);
                        end
                        default:
                        begin
                            nxt_scl_low = 1'b1;
                            nxt_sh      = txb(txn_ff);
                            nxt_bit     = 4'h0;
                            nxt_st      = bootseq_pkg::S_TX;
                        end
                    endcase
            end
            bootseq_pkg::S_TX:
            begin
                if (tick)
                    case (q_ff)
                        2'h0: nxt_sda_low = (bit_ff < 4'h8) ? !sh_ff[7] : 1'b0;
                        2'h1: nxt_scl_low = 1'b0;
                        2'h2: nxt_nack = (bit_ff == 4'h8) && sda_flt;
                        default:
                        begin
                            nxt_scl_low = 1'b1;
                            nxt_sh      = {sh_ff[6:0], 1'b0};
                            nxt_bit     = bit_ff + 4'h1;
                            if (bit_ff == 4'h8)
                            begin
                                nxt_bit = 4'h0;
                                nxt_txn = txn_ff + 3'h1;
                                nxt_sh  = txb(txn_ff + 3'h1);
                                if (nack_ff)
                                begin
                                    nxt_err = 1'b1;
                                    nxt_st  = bootseq_pkg::S_STOP;
                                end
                                else if (txn_ff == 3'h2)
                                    nxt_st = bootseq_pkg::S_RSTART;
                                else if (txn_ff == 3'h3)
                                    nxt_st = bootseq_pkg::S_RX;
                            end
                        end
                    endcase
            end
            bootseq_pkg::S_RX:
            begin
                // [R9] sequential record read, nack ends on end flag
                if (tick)
                    case (q_ff)
                        2'h0: nxt_sda_low = (bit_ff == 4'h8) && !nack_ff;
                        2'h1: nxt_scl_low = 1'b0;
                        2'h2:
                        begin
                            if (bit_ff < 4'h8)
                                nxt_sh = {sh_ff[6:0], sda_flt};
                            if (bit_ff == 4'h7)
                                nxt_nack = (rxn_ff == 3'h0) && sh_ff[`BSEQ_END_BIT-1];
                        end
                        default:
                        begin
                            nxt_scl_low = 1'b1;
                            nxt_bit     = bit_ff + 4'h1;
                            if (bit_ff == 4'h8)
                            begin
                                nxt_bit = 4'h0;
                                nxt_rec = {rec_ff[47:0], sh_ff};
                                nxt_rxn = rxn_ff + 3'h1;
                                if (nack_ff)
                                    nxt_st = bootseq_pkg::S_STOP;
                                else if (rxn_ff == `BSEQ_REC_LAST)
                                begin
                                    nxt_rxn = 3'h0;
                                    nxt_st  = bootseq_pkg::S_PUSH;
                                end
                            end
                        end
                    endcase
            end
            bootseq_pkg::S_PUSH:
            begin
                // bus clock held low while the fifo is full
                nxt_q = 2'h0;
                if (fq.push_ready)
                    nxt_st = bootseq_pkg::S_RX;
            end
            bootseq_pkg::S_STOP:
            begin
                if (tick)
                    case (q_ff)
                        2'h0: nxt_sda_low = 1'b1;
                        2'h1: nxt_scl_low = 1'b0;
                        2'h2: nxt_sda_low = 1'b0;
                        default: nxt_st = bootseq_pkg::S_FINISH;
                    endcase
            end
            bootseq_pkg::S_FINISH: nxt_q = 2'h0;
            default: nxt_st = bootseq_pkg::S_WAIT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_ff <= bootseq_pkg::S_WAIT;
            q_ff <= 2'h0;  tk_ff <= 14'h0000;  bit_ff <= 4'h0;  sh_ff <= 8'h00;
            txn_ff <= 3'h0;  rxn_ff <= 3'h0;  rec_ff <= '0;
            scl_low_ff <= 1'b0;  sda_low_ff <= 1'b0;
            boot_en_ff <= 1'b0;  taken_ff <= 1'b0;
            done_ff <= 1'b0;  err_ff <= 1'b0;  nack_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            q_ff <= nxt_q;  tk_ff <= nxt_tk;  bit_ff <= nxt_bit;  sh_ff <= nxt_sh;
            txn_ff <= nxt_txn;  rxn_ff <= nxt_rxn;  rec_ff <= nxt_rec;
            scl_low_ff <= nxt_scl_low;  sda_low_ff <= nxt_sda_low;
            boot_en_ff <= nxt_boot_en;  taken_ff <= nxt_taken;
            done_ff <= nxt_done;  err_ff <= nxt_err;  nack_ff <= nxt_nack;
        end
    end

    // write output stage fed from the fifo
    assign fq.pop_ready = !wv_ff || wr_ready;
    assign out_load     = fq.pop_valid && fq.pop_ready;
    assign rout         = fq.pop_data;
    always_comb
    begin
        nxt_wv = out_load ? 1'b1 : (wr_ready ? 1'b0 : wv_ff);
        nxt_wa = wa_ff;  nxt_wd = wd_ff;  nxt_wt = wt_ff;  nxt_walt = walt_ff;
        if (out_load)
        begin
            // [R4] [R5] [R7] base joined to 20 bit offset
            nxt_wa   = {rout.alt ? alt_space_base_reg : `BSEQ_DEF_BASE, rout.offset};
            // [R6] alternate writes routed to chosen unit
            nxt_wt   = rout.alt ? alt_space_target_reg : `BSEQ_DEF_TARGET;
            nxt_wd   = rout.data;
            nxt_walt = rout.alt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wv_ff <= 1'b0;  wa_ff <= 32'h0000_0000;  wd_ff <= 32'h0000_0000;
            wt_ff <= 4'h0;  walt_ff <= 1'b0;
        end
        else
        begin
            wv_ff <= nxt_wv;  wa_ff <= nxt_wa;  wd_ff <= nxt_wd;
            wt_ff <= nxt_wt;  walt_ff <= nxt_walt;
        end
    end

    // [R1] outputs and pins
    assign wr_valid    = wv_ff;
    assign wr_addr     = wa_ff;
    assign wr_data     = wd_ff;
    assign wr_target   = wt_ff;
    assign wr_alt      = walt_ff;
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_n    = !scl_low_ff;
    assign sda_oe_n    = !sda_low_ff;
    assign boot_active = (st_ff != bootseq_pkg::S_WAIT) && !done_ff;
    assign boot_done   = done_ff;
    assign boot_error  = err_ff;

    a_wait_lock: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
        (st_ff == bootseq_pkg::S_WAIT && !lock_flt) |=> st_ff == bootseq_pkg::S_WAIT)
        else $error("sequencer left wait before lock");
    a_div_range: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
        qtr >= 14'h0028 && qtr <= 14'h2000)
        else $error("quarter period outside limits");
    a_mode_frozen: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
        taken_ff |=> $stable(boot_en_ff) && taken_ff)
        else $error("boot mode changed after selection");
    a_alt_addr: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
        (out_load && rout.alt) |=> wr_addr == {$past(alt_space_base_reg), $past(rout.offset)})
        else $error("alternate address not base joined to offset");
    a_def_space: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
        (out_load && !rout.alt) |=> !wr_alt && wr_addr[31:20] == `BSEQ_DEF_BASE)
        else $error("default write left default space");
    a_alt_target: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
        (out_load && rout.alt) |=> wr_alt && wr_target == $past(alt_space_target_reg))
        else $error("alternate write to wrong target");
    a_no_write_disabled: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        (taken_ff && !boot_en_ff) |-> !wr_valid && !fq.push_valid)
        else $error("write while sequencer disabled");
    a_start_cond: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
        (st_ff == bootseq_pkg::S_START && tick && q_ff == 2'h0)
        |=> sda_low_ff && !scl_low_ff)
        else $error("start condition malformed");
    a_push_stall: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
        (st_ff == bootseq_pkg::S_PUSH && !fq.push_ready) |=> st_ff == bootseq_pkg::S_PUSH
        && scl_low_ff)
        else $error("full fifo did not stall the bus");
endmodule // i2c_boot_sequencer

// [i2c_boot_sequencer_tb_top.sv]
`timescale 1ns/100ps
`include "bootseq_consts.svh"

module i2c_boot_sequencer_tb_top;
    logic        clk;
    logic        sys_rst;
    logic [1:0]  boot_mode_strap_inputs;
    logic        dll_locked;
    logic [15:0] clk_div;
    logic [11:0] alt_space_base_reg;
    logic [3:0]  alt_space_target_reg;
    logic        scl, sda, scl_o, sda_o, scl_oe_n, sda_oe_n, scl_pull_n, sda_pull_n;
    logic        wr_valid, wr_ready, wr_alt, boot_active, boot_done, boot_error;
    logic [31:0] wr_addr, wr_data;
    logic [3:0]  wr_target;
    logic        slow, nack_dev;
    int          n_fail, checked, cyc;
    realtime     t0;

    // pulled-up open drain lines
    assign scl = (scl_oe_n | scl_o) & scl_pull_n;
    assign sda = (sda_oe_n | sda_o) & sda_pull_n;

    i2c_boot_sequencer i2c_boot_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
        .boot_mode_strap_inputs(boot_mode_strap_inputs), .dll_locked(dll_locked),
        .clk_div(clk_div), .alt_space_base_reg(alt_space_base_reg),
        .alt_space_target_reg(alt_space_target_reg), .scl_i(scl), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_alt(wr_alt), .wr_target(wr_target), .boot_active(boot_active),
        .boot_done(boot_done), .boot_error(boot_error));

    rom_model rom_model_inst (.scl(scl), .sda(sda), .slow(slow), .nack_dev(nack_dev),
        .scl_pull_n(scl_pull_n), .sda_pull_n(sda_pull_n));

    // clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 100000)
        begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: pick = wr_valid;
            1: pick = boot_done;
            2: pick = boot_error;
            default: pick = boot_active;
        endcase
    endfunction

    // bounded wait for one status output
    task automatic wait_hi(input int k, input int lim);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        check(32'(pick(k)), 32'h0000_0001);
    endtask

    task automatic do_reset(input logic [1:0] mode);
        @(negedge clk);
        sys_rst = 1'b1;
        dll_locked = 1'b0;
        boot_mode_strap_inputs = mode;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
    endtask

    // one register write, held off by the sink first
    task automatic take_write(input logic [31:0] a, input logic [31:0] d,
                              input logic alt, input logic [3:0] tgt);
        wait_hi(0, 40000);
        check(wr_addr, a);
        check(wr_data, d);
        check(32'(wr_alt), 32'(alt));
        check(32'(wr_target), 32'(tgt));
        repeat (2) @(negedge clk);
        check({wr_addr[30:0], wr_valid}, {a[30:0], 1'b1});
        wr_ready = 1'b1;
        @(negedge clk);
        wr_ready = 1'b0;
        @(negedge clk);
    endtask

    task automatic boot_run(input logic [11:0] base, input logic [3:0] tgt,
                            input logic [15:0] div, input int per);
        do_reset(`BSEQ_STRAP_SEL);
        alt_space_base_reg = base;
        alt_space_target_reg = tgt;
        clk_div = div;
        repeat (40) @(negedge clk);
        check(32'({boot_active, scl_oe_n, sda_oe_n}), 32'h0000_0003);
        dll_locked = 1'b1;
        wait_hi(3, 20);
        boot_mode_strap_inputs = 2'h0;
        if (per > 0)
        begin
            repeat (2) @(posedge scl);
            t0 = $realtime;
            @(posedge scl);
            check(32'(int'(($realtime - t0) / 40.0)), 32'(per));
        end
        take_write(32'h0001_2345, 32'hdead_beef, 1'b0, 4'h0);
        take_write({base, 20'hab_cde}, 32'h0bad_f00d, 1'b1, tgt);
        wait_hi(1, 5000);
        check(32'({boot_active, boot_error, wr_valid}), 32'h0000_0000);
    endtask

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        boot_mode_strap_inputs = 2'h0;
        dll_locked = 1'b0;
        clk_div = 16'h0010;
        alt_space_base_reg = 12'h000;
        alt_space_target_reg = 4'h0;
        wr_ready = 1'b0;
        slow = 1'b0;
        nack_dev = 1'b0;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        boot_run(12'hfe1, 4'h9, 16'h0010, `BSEQ_DIV_MIN);
        slow = 1'b1;
        boot_run(12'h012, 4'h3, 16'h00c8, 0);
        nack_dev = 1'b1;
        do_reset(`BSEQ_STRAP_SEL);
        dll_locked = 1'b1;
        wait_hi(2, 4000);
        check(32'(wr_valid), 32'h0000_0000);
        nack_dev = 1'b0;
        do_reset(2'h0);
        dll_locked = 1'b1;
        wait_hi(1, 40);
        boot_mode_strap_inputs = `BSEQ_STRAP_SEL;
        repeat (20) @(negedge clk);
        check(32'({boot_active, scl_oe_n, sda_oe_n, wr_valid, scl_o, sda_o}), 32'h0000_0018);
        test_done();
    end
endmodule // i2c_boot_sequencer_tb_top

// [rec_fifo.sv]
`timescale 1ns/100ps

module rec_fifo #(
    parameter int W = 53,
    parameter int D = 32
) (
    input wire logic  clk,        // platform clock
    input wire logic  sys_rst,    // synchronous reset
    rec_fifo_if.buf_side f        // push and pop sides
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_ff;
    logic [AW:0]  rd_ptr_ff;
    logic [AW:0]  nxt_wr_ptr;
    logic [AW:0]  nxt_rd_ptr;
    logic         full;
    logic         empty;
    logic         do_push;
    logic         do_pop;

    // honest full and empty from pointers with wrap bit
    assign empty        = (wr_ptr_ff == rd_ptr_ff);
    assign full         = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0])
                          && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
    assign f.push_ready = !full;
    assign f.pop_valid  = !empty;
    assign f.pop_data   = mem[rd_ptr_ff[AW-1:0]];
    assign do_push      = f.push_valid && !full;
    assign do_pop       = !empty && f.pop_ready;

    // pointer advance
    always_comb
    begin
        nxt_wr_ptr = wr_ptr_ff + (AW+1)'(do_push);
        nxt_rd_ptr = rd_ptr_ff + (AW+1)'(do_pop);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    // storage write, one entry per push
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wr_ptr_ff[AW-1:0]] <= f.push_data;
    end
endmodule // rec_fifo

// [rec_fifo_if.sv]
`timescale 1ns/100ps

interface rec_fifo_if #(parameter int W = 53);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport src (output push_valid, output push_data, input push_ready);
    modport snk (input pop_valid, input pop_data, output pop_ready);
    modport buf_side (input push_valid, input push_data, output push_ready,
                      output pop_valid, output pop_data, input pop_ready);
endinterface

// [rom_model.sv]
`timescale 1ns/100ps

module rom_model (
    input  wire logic scl,        // bus clock level
    input  wire logic sda,        // bus data level
    input  wire logic slow,       // stretch clock low phase
    input  wire logic nack_dev,   // refuse device byte
    output logic      scl_pull_n, // low while holding clock
    output logic      sda_pull_n  // low while pulling data
);
    logic [7:0]  mem [16];
    logic [7:0]  sr;
    logic [15:0] ptr;
    int          bitn;
    int          hdr;
    logic        rd;
    logic        live;
    logic        mack;

    // two records then the end marker
    initial
    begin
        mem = '{8'h01, 8'h23, 8'h45, 8'hde, 8'had, 8'hbe, 8'hef, 8'h8a,
                8'hbc, 8'hde, 8'h0b, 8'had, 8'hf0, 8'h0d, 8'h40, 8'h00};
        scl_pull_n = 1'b1;
        sda_pull_n = 1'b1;
        live = 1'b0;
        rd = 1'b0;
        bitn = 0;
        hdr = 0;
        ptr = 16'h0000;
    end

    // start and stop: data edge while clock high
    always @(sda)
    begin
        if (scl === 1'b1)
        begin
            live = !sda;
            bitn = -1;     // clock fall after start is not a bit
            hdr = 0;
            rd = 1'b0;
            sda_pull_n = 1'b1;
        end
    end

    // load next byte and put out its top bit
    task automatic send();
        sr = mem[ptr[3:0]];
        ptr = ptr + 16'h0001;
        sda_pull_n = sr[7];
    endtask

    always @(posedge scl)
    begin
        if (live && bitn < 8 && !rd)
            sr = {sr[6:0], sda};
        if (live && bitn == 8 && rd)
            mack = sda;
    end

    always @(negedge scl)
    begin
        if (live)
        begin
            bitn = bitn + 1;
            if (bitn < 8 && rd)
                sda_pull_n = sr[7 - bitn];
            else if (bitn == 8)
                sda_pull_n = rd | !(hdr != 0 || (sr[7:1] == 7'h50 && !nack_dev));
            else if (bitn == 9)
            begin
                bitn = 0;
                if (rd && !mack)
                    send();
                else if (rd || sda_pull_n)
                begin
                    live = 1'b0;   // refused: go quiet
                    sda_pull_n = 1'b1;
                end
                else
                begin
                    sda_pull_n = 1'b1;
                    if (hdr == 0)
                        rd = sr[0];
                    if (hdr == 1)
                        ptr[15:8] = sr;
                    if (hdr == 2)
                        ptr[7:0] = sr;
                    if (rd)
                        send();
                    hdr = hdr + 1;
                end
            end
        end
    end

    // slow mode holds the clock low after each fall
    always @(negedge scl)
    begin
        if (slow)
        begin
            scl_pull_n = 1'b0;
            #5000;
            scl_pull_n = 1'b1;
        end
    end
endmodule // rom_model
